/* design/ppc_pkg.sv */
// ppc_pkg: constants and carrier types for the port phy control register bank
// assumes: one clock domain, APB with 32-bit data
package ppc_pkg;

    localparam int unsigned        ADDR_W             = 12;
    localparam int unsigned        DATA_W             = 32;
    localparam int unsigned        REG_W              = 16;

    // register index 0x2 is not a multiple of four: byte address is four times index
    localparam logic [ADDR_W-1:0]  CTRL_FOUR_IDX      = 12'h0002;
    localparam logic [ADDR_W-1:0]  CTRL_FOUR_ADDR     = 12'h0008;
    // second view of the same storage (alias bank)
    localparam logic [ADDR_W-1:0]  ALIAS_CTRL_ADDR    = 12'h0010;
    localparam logic [ADDR_W-1:0]  ALIAS_ADV_ADDR     = 12'h0014;
    // read-only status view of the resolved link settings
    localparam logic [ADDR_W-1:0]  LINK_STAT_ADDR     = 12'h0018;

    localparam logic [REG_W-1:0]   CTRL_FOUR_RESET    = 16'h009F;
    // bits 12 and 8 are reserved in the control view
    localparam logic [REG_W-1:0]   CTRL_FOUR_WMASK    = 16'hEEFF;

    localparam int unsigned        BIT_LAMP_OFF       = 15;
    localparam int unsigned        BIT_TX_DIS         = 14;
    localparam int unsigned        BIT_RENEG          = 13;
    localparam int unsigned        BIT_PWR_DOWN       = 11;
    localparam int unsigned        BIT_XOVER_DIS      = 10;
    localparam int unsigned        BIT_FORCE_MDIX     = 9;
    localparam int unsigned        BIT_AN_EN          = 7;
    localparam int unsigned        BIT_FORCE_100      = 6;
    localparam int unsigned        BIT_FORCE_FULL     = 5;
    localparam int unsigned        BIT_ADV_PAUSE      = 4;
    localparam int unsigned        BIT_ADV_100F       = 3;
    localparam int unsigned        BIT_ADV_100H       = 2;
    localparam int unsigned        BIT_ADV_10F        = 1;
    localparam int unsigned        BIT_ADV_10H        = 0;

    // alias control view: bit positions
    localparam int unsigned        AL_LAMP_OFF        = 0;
    localparam int unsigned        AL_TX_DIS          = 1;
    localparam int unsigned        AL_RSVD            = 2;
    localparam int unsigned        AL_XOVER_DIS       = 3;
    localparam int unsigned        AL_FORCE_MDIX      = 4;
    localparam int unsigned        AL_FORCE_FULL      = 8;
    localparam int unsigned        AL_RENEG           = 9;
    localparam int unsigned        AL_PWR_DOWN        = 11;
    localparam int unsigned        AL_AN_EN           = 12;
    localparam int unsigned        AL_FORCE_100       = 13;
    // alias advertisement view: bits 10,8,7,6,5
    localparam int unsigned        AL_ADV_PAUSE       = 10;
    localparam int unsigned        AL_ADV_100F        = 8;
    localparam int unsigned        AL_ADV_100H        = 7;
    localparam int unsigned        AL_ADV_10F         = 6;
    localparam int unsigned        AL_ADV_10H         = 5;

    localparam int unsigned        LAMP_N             = 4;

    typedef struct packed {
        logic        tx_disable;
        logic        power_down;
        logic        xover_auto;
        logic        force_mdix;
        logic        an_enable;
        logic        speed_100;
        logic        full_duplex;
        logic [4:0]  advert;
    } ppc_phy_ctl_type;

endpackage

/* design/ppc_top.sv */
// ppc_top: port phy control register with APB slave, lamp gating and phy controls
// assumes: APB master on pclk, phy core consumes ppc_phy_ctl_type, lamps active low
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ppc_top (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ppc_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [ppc_pkg::DATA_W-1:0]     pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [ppc_pkg::DATA_W-1:0]     prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [ppc_pkg::LAMP_N-1:0]     lamp_in_n,
    input  wire logic                           an_failed,
    input  wire logic                           an_done,
    output logic      [ppc_pkg::LAMP_N-1:0]     port_lamp_n,
    output ppc_pkg::ppc_phy_ctl_type            phy_ctl,
    output logic                                an_restart
);
    import ppc_pkg::*;

    // ------------------------------------------------------------
    // storage and bus decode
    // ------------------------------------------------------------
    logic [REG_W-1:0]      ctrl_r;
    logic [REG_W-1:0]      ctrl_nxt;
    logic                  rsvd12_r;
    logic [LAMP_N-1:0]     lamp_s1_r;
    logic [LAMP_N-1:0]     lamp_s2_r;
    logic [1:0]            fail_sync_r;
    logic [1:0]            done_sync_r;
    logic                  access;
    logic                  wr_main;
    logic                  wr_al_ctl;
    logic                  wr_al_adv;
    logic                  wr_low;
    logic                  wr_high;
    logic [REG_W-1:0]      al_ctl_view;
    logic [REG_W-1:0]      al_adv_view;
    logic [REG_W-1:0]      link_view;
    logic                  mapped;
    logic [DATA_W-1:0]     rd_data;
    ppc_phy_ctl_type       ctl_nxt;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return a == b;
    endfunction

    assign access    = psel && penable && pready;
    assign wr_low    = pstrb[0];
    assign wr_high   = pstrb[1];
    assign wr_main   = access && pwrite && addr_hit(paddr, CTRL_FOUR_ADDR);
    assign wr_al_ctl = access && pwrite && addr_hit(paddr, ALIAS_CTRL_ADDR);
    assign wr_al_adv = access && pwrite && addr_hit(paddr, ALIAS_ADV_ADDR);

    always_comb begin
        al_ctl_view                = '0;
        al_ctl_view[AL_LAMP_OFF]   = ctrl_r[BIT_LAMP_OFF];
        al_ctl_view[AL_TX_DIS]     = ctrl_r[BIT_TX_DIS];
        al_ctl_view[AL_RSVD]       = rsvd12_r;
        al_ctl_view[AL_XOVER_DIS]  = ctrl_r[BIT_XOVER_DIS];
        al_ctl_view[AL_FORCE_MDIX] = ctrl_r[BIT_FORCE_MDIX];
        al_ctl_view[AL_FORCE_FULL] = ctrl_r[BIT_FORCE_FULL];
        al_ctl_view[AL_RENEG]      = ctrl_r[BIT_RENEG];
        al_ctl_view[AL_PWR_DOWN]   = ctrl_r[BIT_PWR_DOWN];
        al_ctl_view[AL_AN_EN]      = ctrl_r[BIT_AN_EN];
        al_ctl_view[AL_FORCE_100]  = ctrl_r[BIT_FORCE_100];
        al_adv_view                = '0;
        al_adv_view[AL_ADV_PAUSE]  = ctrl_r[BIT_ADV_PAUSE];
        al_adv_view[AL_ADV_100F]   = ctrl_r[BIT_ADV_100F];
        al_adv_view[AL_ADV_100H]   = ctrl_r[BIT_ADV_100H];
        al_adv_view[AL_ADV_10F]    = ctrl_r[BIT_ADV_10F];
        al_adv_view[AL_ADV_10H]    = ctrl_r[BIT_ADV_10H];
        link_view                  = '0;
        link_view[BIT_FORCE_100]   = ctl_nxt.speed_100;
        link_view[BIT_FORCE_FULL]  = ctl_nxt.full_duplex;
        link_view[1]               = done_sync_r[1];
        link_view[0]               = fail_sync_r[1];
    end

    // one storage, writes from the main, alias control or alias advertisement view
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_main) begin
            if (wr_low) begin
                ctrl_nxt[7:0] = pwdata[7:0] & CTRL_FOUR_WMASK[7:0];
            end
            if (wr_high) begin
                ctrl_nxt[15:8] = pwdata[15:8] & CTRL_FOUR_WMASK[15:8];
            end
        end else if (wr_al_ctl) begin
            if (wr_low) begin
                ctrl_nxt[BIT_LAMP_OFF]   = pwdata[AL_LAMP_OFF];
                ctrl_nxt[BIT_TX_DIS]     = pwdata[AL_TX_DIS];
                ctrl_nxt[BIT_XOVER_DIS]  = pwdata[AL_XOVER_DIS];
                ctrl_nxt[BIT_FORCE_MDIX] = pwdata[AL_FORCE_MDIX];
            end
            if (wr_high) begin
                ctrl_nxt[BIT_FORCE_FULL] = pwdata[AL_FORCE_FULL];
                ctrl_nxt[BIT_RENEG]      = pwdata[AL_RENEG];
                ctrl_nxt[BIT_PWR_DOWN]   = pwdata[AL_PWR_DOWN];
                ctrl_nxt[BIT_AN_EN]      = pwdata[AL_AN_EN];
                ctrl_nxt[BIT_FORCE_100]  = pwdata[AL_FORCE_100];
            end
        end else if (wr_al_adv) begin
            if (wr_low) begin
                ctrl_nxt[BIT_ADV_100H] = pwdata[AL_ADV_100H];
                ctrl_nxt[BIT_ADV_10F]  = pwdata[AL_ADV_10F];
                ctrl_nxt[BIT_ADV_10H]  = pwdata[AL_ADV_10H];
            end
            if (wr_high) begin
                ctrl_nxt[BIT_ADV_PAUSE] = pwdata[AL_ADV_PAUSE];
                ctrl_nxt[BIT_ADV_100F]  = pwdata[AL_ADV_100F];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_FOUR_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // reserved bit held only in the alias view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd12_r <= 1'b0;
        end else if (wr_al_ctl && wr_low) begin
            rsvd12_r <= pwdata[AL_RSVD];
        end
    end

    // ------------------------------------------------------------
    // APB read path and response
    // ------------------------------------------------------------
    always_comb begin
        rd_data = '0;
        mapped  = 1'b1;
        if (addr_hit(paddr, CTRL_FOUR_ADDR)) begin
            rd_data[REG_W-1:0] = ctrl_r;
        end else if (addr_hit(paddr, ALIAS_CTRL_ADDR)) begin
            rd_data[REG_W-1:0] = al_ctl_view;
        end else if (addr_hit(paddr, ALIAS_ADV_ADDR)) begin
            rd_data[REG_W-1:0] = al_adv_view;
        end else if (addr_hit(paddr, LINK_STAT_ADDR)) begin
            rd_data[REG_W-1:0] = link_view;
        end else begin
            mapped = 1'b0;
        end
    end

    // ready in the first cycle of the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? '0 : rd_data;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_s1_r   <= '1;
            lamp_s2_r   <= '1;
            fail_sync_r <= '0;
            done_sync_r <= '0;
        end else begin
            lamp_s1_r   <= lamp_in_n;
            lamp_s2_r   <= lamp_s1_r;
            fail_sync_r <= {fail_sync_r[0], an_failed};
            done_sync_r <= {done_sync_r[0], an_done};
        end
    end

    // ------------------------------------------------------------
    // phy controls
    // ------------------------------------------------------------
    always_comb begin
        ctl_nxt.tx_disable  = ctrl_r[BIT_TX_DIS];
        ctl_nxt.power_down  = ctrl_r[BIT_PWR_DOWN];
        ctl_nxt.xover_auto  = !ctrl_r[BIT_XOVER_DIS];
        ctl_nxt.force_mdix  = ctrl_r[BIT_XOVER_DIS] && ctrl_r[BIT_FORCE_MDIX];
        ctl_nxt.an_enable   = ctrl_r[BIT_AN_EN];
        ctl_nxt.speed_100   = ctrl_r[BIT_FORCE_100];
        ctl_nxt.full_duplex = ctrl_r[BIT_FORCE_FULL];
        ctl_nxt.advert      = ctrl_r[BIT_ADV_PAUSE:BIT_ADV_10H];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_ctl <= '{default: 1'b0, xover_auto: 1'b1, an_enable: 1'b1,
                         advert: CTRL_FOUR_RESET[BIT_ADV_PAUSE:BIT_ADV_10H]};
        end else begin
            phy_ctl <= ctl_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_restart <= 1'b0;
        end else begin
            an_restart <= (wr_main && wr_high && pwdata[BIT_RENEG])
                       || (wr_al_ctl && wr_high && pwdata[AL_RENEG]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_lamp_n <= '1;
        end else begin
            port_lamp_n <= ctrl_r[BIT_LAMP_OFF] ? '1 : lamp_s2_r;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    lamp_blank_a: assert property (ctrl_r[BIT_LAMP_OFF] |=> port_lamp_n == '1)
        else $error("lamps not blanked");

    lamp_pass_a: assert property (!ctrl_r[BIT_LAMP_OFF] |=>
        port_lamp_n == $past(lamp_s2_r))
        else $error("lamps not passed through");

    tx_stop_a: assert property (ctrl_r[BIT_TX_DIS] |=> phy_ctl.tx_disable)
        else $error("transmitter not stopped");

    tx_run_a: assert property (!ctrl_r[BIT_TX_DIS] |=> !phy_ctl.tx_disable)
        else $error("transmitter stopped while enabled");

    reneg_pulse_a: assert property ((wr_main && wr_high && pwdata[BIT_RENEG]) |=>
        an_restart)
        else $error("renegotiation not started");

    reneg_alias_a: assert property ((wr_al_ctl && wr_high && pwdata[AL_RENEG]) |=>
        an_restart)
        else $error("alias renegotiation not started");

    reneg_quiet_a: assert property (!(wr_main || wr_al_ctl) |=> !an_restart)
        else $error("spurious renegotiation");

    pwr_down_a: assert property (ctrl_r[BIT_PWR_DOWN] |=> phy_ctl.power_down)
        else $error("power down not applied");

    pwr_up_a: assert property (!ctrl_r[BIT_PWR_DOWN] |=> !phy_ctl.power_down)
        else $error("power down while cleared");

    xover_off_a: assert property (ctrl_r[BIT_XOVER_DIS] |=> !phy_ctl.xover_auto)
        else $error("auto crossover still on");

    xover_on_a: assert property (!ctrl_r[BIT_XOVER_DIS] |=> phy_ctl.xover_auto)
        else $error("auto crossover off while enabled");

    // forced crossover only with auto off
    mdix_force_a: assert property (phy_ctl.force_mdix |-> !phy_ctl.xover_auto)
        else $error("crossover forced while auto on");

    mdix_set_a: assert property ((ctrl_r[BIT_XOVER_DIS] && ctrl_r[BIT_FORCE_MDIX]) |=>
        phy_ctl.force_mdix)
        else $error("crossover not forced");

    an_enable_a: assert property (phy_ctl.an_enable == $past(ctrl_r[BIT_AN_EN]))
        else $error("negotiation enable not from register");

    an_speed_a: assert property ($past(ctrl_r[BIT_FORCE_100]) == phy_ctl.speed_100)
        else $error("speed not from register");

    duplex_a: assert property (wr_main && wr_low |=>
        ##1 phy_ctl.full_duplex == ctrl_r[BIT_FORCE_FULL])
        else $error("duplex mismatch");

    advert_a: assert property (
        phy_ctl.advert == $past(ctrl_r[BIT_ADV_PAUSE:BIT_ADV_10H]))
        else $error("advertisement mismatch");

    alias_view_a: assert property (wr_al_ctl && wr_high |=>
        ctrl_r[BIT_PWR_DOWN] == $past(pwdata[AL_PWR_DOWN]))
        else $error("alias write lost");

    alias_adv_a: assert property (wr_al_adv && wr_high |=>
        ctrl_r[BIT_ADV_PAUSE] == $past(pwdata[AL_ADV_PAUSE]))
        else $error("alias advertisement write lost");

    main_read_a: assert property ((psel && !penable && !pwrite &&
        addr_hit(paddr, CTRL_FOUR_ADDR)) |=> prdata[REG_W-1:0] == $past(ctrl_r))
        else $error("main view read mismatch");

    apb_ready_a: assert property ((psel && !penable) |=> pready)
        else $error("no ready in access phase");

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");

    unmapped_err_a: assert property ((psel && !penable && !mapped) |=> pslverr)
        else $error("no error for unmapped address");

    main_wr_c: cover property (wr_main);
    reneg_c: cover property (an_restart);
    alias_wr_c: cover property (wr_al_ctl ##[1:20] (access && !pwrite && addr_hit(paddr, CTRL_FOUR_ADDR)));
    lamp_blank_c: cover property (ctrl_r[BIT_LAMP_OFF] && lamp_s2_r != '1);
    unmapped_c: cover property (pslverr);

endmodule

`default_nettype wire

/* tb/ppc_phy_model.sv */
// ppc_phy_model: behavioural phy core on the far side of the control register block
// assumes: one clock with ppc_top, lamp drive active low, control levels from phy_ctl
`timescale 1ns/1ps
`default_nettype none
module ppc_phy_model
    import ppc_pkg::*;
#(
    parameter int DONE_DLY = 8
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire ppc_pkg::ppc_phy_ctl_type  phy_ctl,
    input  wire logic                      an_restart,
    output logic [ppc_pkg::LAMP_N-1:0]     lamp_in_n,
    output logic                           an_done,
    output logic                           an_failed,
    output int                             restarts
);
    int cnt;

    // lamps: duplex, speed, link, low when lit
    assign lamp_in_n = ~{1'b0, phy_ctl.full_duplex, phy_ctl.speed_100, an_done};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restarts <= 0;
        end else if (an_restart) begin
            restarts <= restarts + 1;
        end
    end

    // negotiation fails when none of advert[3:0] is advertised; the pause bit is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_done   <= 1'b0;
            an_failed <= 1'b0;
            cnt       <= 0;
        end else if (phy_ctl.power_down) begin
            an_done <= 1'b0;
            cnt     <= 0;
        end else if (an_restart) begin
            an_done <= 1'b0;
            cnt     <= DONE_DLY;
        end else if (cnt == 1) begin
            an_done   <= 1'b1;
            an_failed <= (phy_ctl.advert[3:0] == 4'h0);
            cnt       <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// tb_top: register-level bench for ppc_top over APB, with the phy model attached
// assumes: ppc_pkg compiled first, one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD t=%0t act=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import ppc_pkg::*;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0]      paddr;
    logic [DATA_W-1:0]      pwdata, prdata, rd;
    logic [3:0]             pstrb;
    logic [LAMP_N-1:0]      lamp_in_n, port_lamp_n;
    logic                   an_failed, an_done, an_restart;
    ppc_phy_ctl_type        phy_ctl;
    int                     restarts, num_errors, samples_checked, base;
    logic [15:0]            pats [16] = '{16'h8000, 16'h4000, 16'h0800, 16'h0400, 16'h0600,
                                16'h0200, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
                                16'h0004, 16'h0002, 16'h0001, 16'hFFFF, 16'h0000};

    ppc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lamp_in_n(lamp_in_n), .an_failed(an_failed),
        .an_done(an_done), .port_lamp_n(port_lamp_n), .phy_ctl(phy_ctl),
        .an_restart(an_restart));
    ppc_phy_model u_phy (.pclk(pclk), .presetn(presetn), .phy_ctl(phy_ctl),
        .an_restart(an_restart), .lamp_in_n(lamp_in_n), .an_done(an_done),
        .an_failed(an_failed), .restarts(restarts));

    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // ----------------------------------------
    // bus and checking tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("BAD t=%0t act=%h exp=%h", $time, pready, 1'b1);
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (6) @(posedge pclk);
        #1;
    endtask

    task automatic wr_ctl(input logic [15:0] v);
        apb(1'b1, CTRL_FOUR_ADDR, {16'h0000, v}, 4'hF);
        settle();
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        `CHK({err, rd}, {1'b0, e})
    endtask

    function automatic ppc_phy_ctl_type exp_ctl(input logic [15:0] x);
        ppc_phy_ctl_type e;
        e.tx_disable  = x[14];
        e.power_down  = x[11];
        e.xover_auto  = ~x[10];
        e.force_mdix  = x[9] & x[10];
        e.an_enable   = x[7];
        e.speed_100   = x[6];
        e.full_duplex = x[5];
        e.advert      = x[4:0];
        return e;
    endfunction

    task automatic chk_state(input logic [15:0] x);
        ppc_phy_ctl_type e, a;
        e = exp_ctl(x);
        a = phy_ctl;
        `CHK(a, e)
        `CHK(port_lamp_n, x[15] ? 4'hF : lamp_in_n)
        rdchk(CTRL_FOUR_ADDR, {16'h0000, x & 16'hEEFF});
    endtask

    task automatic wait_link();
        for (int n = 0; n < 64 && an_done !== 1'b1; n++) @(posedge pclk);
        if (an_done !== 1'b1) begin
            num_errors++;
            $display("BAD t=%0t act=%h exp=%h", $time, an_done, 1'b1);
            tally_and_finish();
        end
        settle();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        num_errors = 0;
        samples_checked = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (2) @(posedge pclk);
        `CHK({pready, port_lamp_n}, 5'h0F)
        presetn <= 1'b1;
        settle();
        chk_state(16'h009F);
        rdchk(ALIAS_CTRL_ADDR, 32'h0000_1000);
        rdchk(ALIAS_ADV_ADDR, 32'h0000_05E0);
        rdchk(LINK_STAT_ADDR, 32'h0000_0000);
        $display("test reset values done");
        foreach (pats[i]) begin
            wr_ctl(pats[i]);
            chk_state(pats[i]);
            if (pats[i] == 16'hFFFF) begin
                apb(1'b0, ALIAS_CTRL_ADDR, 32'h0, 4'h0);
                `CHK(rd & 32'hFFFF_FFFB, 32'h0000_3B1B)
                rdchk(ALIAS_ADV_ADDR, 32'h0000_05E0);
            end
        end
        `CHK(restarts, 1)
        $display("test walking bits done");
        apb(1'b1, CTRL_FOUR_ADDR, 32'h0000_C055, 4'b0001);
        settle();
        chk_state(16'h0055);
        apb(1'b1, CTRL_FOUR_ADDR, 32'h0000_C0AA, 4'b0010);
        settle();
        chk_state(16'hC055);
        apb(1'b1, ALIAS_CTRL_ADDR, 32'h0000_2001, 4'hF);
        settle();
        chk_state(16'h8055);
        apb(1'b1, ALIAS_ADV_ADDR, 32'h0000_0100, 4'hF);
        settle();
        chk_state(16'h8048);
        rdchk(ALIAS_ADV_ADDR, 32'h0000_0100);
        $display("test strobes and alias done");
        apb(1'b1, 12'h004, 32'h0000_FFFF, 4'hF);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h00C, 32'h0, 4'h0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        chk_state(16'h8048);
        $display("test unmapped done");
        base = restarts;
        wr_ctl(16'h209F);
        wait_link();
        `CHK(restarts, base + 1)
        rdchk(LINK_STAT_ADDR, 32'h0000_0002);
        wr_ctl(16'h20A0);
        wait_link();
        rdchk(LINK_STAT_ADDR, 32'h0000_0023);
        chk_state(16'h20A0);
        wr_ctl(16'h0080);
        `CHK(restarts, base + 2)
        $display("test renegotiation done");
        tally_and_finish();
    end
endmodule
`undef CHK
`default_nettype wire
